// [hdl/tpc_map.vh]
`ifndef TPC_MAP_VH
`define TPC_MAP_VH
// APB register byte offsets
`define TPC_OFF_CTL0      12'h000
`define TPC_OFF_CTL1      12'h004
`define TPC_OFF_COUNT     12'h008
`define TPC_OFF_RELOAD    12'h00c
`define TPC_OFF_PWM       12'h010
`define TPC_OFF_DEADBAND  12'h014
`define TPC_OFF_STATUS    12'h018
// control_reg_0 fields
`define TPC_C0_MODEHI     0
// control_reg_1 fields
`define TPC_C1_MODE_LSB   0
`define TPC_C1_MODE_MSB   2
`define TPC_C1_PRES_LSB   3
`define TPC_C1_PRES_MSB   5
`define TPC_C1_POL        6
`define TPC_C1_EN         7
// Auxiliary bit in control_reg_0
`define TPC_C0_OUTEN      1
// Mode codes {mode_select_high_bit, mode_select_field}
`define TPC_MODE_CMPCNT   4'h8
`define TPC_MODE_PWM1     4'h3
`define TPC_MODE_PWM2     4'h9
// Reset and restart values, deadband limit and width
`define TPC_COUNT_RST     16'h0001
`define TPC_RELOAD_RST    16'hffff
`define TPC_DB_MAX        8'h80
`define TPC_DB_W          8
`endif

// [hdl/tpc_deadband.v]
`timescale 1ns/100ps
`default_nettype none
// Delays rising edges of one output by a programmable count
module tpc_deadband (
   // Clock and reset
   input  wire       clk,
   input  wire       reset,
   // Control
   input  wire [7:0] delay,
   input  wire       level_in,
   // Delayed level
   output reg        level_out
);
   reg [7:0] cnt_reg;

   // Falls pass at once; rises wait out the delay, output stays low meanwhile
   always @(posedge clk) begin
      if (reset) begin
         cnt_reg   <= 8'h00;
         level_out <= 1'b0;
      end else if (!level_in) begin
         cnt_reg   <= 8'h00;
         level_out <= 1'b0;
      end else if (cnt_reg >= delay) begin
         level_out <= 1'b1;
      end else begin
         cnt_reg   <= cnt_reg + 8'h01;
      end
   end
endmodule // tpc_deadband
`default_nettype wire

// [hdl/tpc_timer.v]
`timescale 1ns/100ps
`default_nettype none
`include "tpc_map.vh"
module tpc_timer (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Comparator and pins
   input  wire        cmp_out,
   output reg         timer_out,
   output reg         timer_out_en,
   output reg         timer_out_n,
   output reg         shared_pin_is_comp,
   // Interrupt request
   output reg         timer_irq
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   reg  [7:0]  ctl0_reg;
   reg  [7:0]  ctl1_reg;
   reg  [15:0] count_reg;
   reg  [15:0] reload_reg;
   reg  [15:0] pwm_reg;
   reg  [7:0]  db_reg;
   reg  [6:0]  pres_reg;
   reg         cmp_q1_reg;
   reg         cmp_q2_reg;
   reg         cmp_q3_reg;
   reg         out_reg;
   reg         state_reg;
   reg  [3:0]  mode_next;
   reg  [15:0] count_next;
   reg         out_next;
   reg         tick;
   reg         cmp_edge;
   wire        db_p;
   wire        db_n;
   wire        acc;
   wire        wr;
   wire        en;
   wire        pol;
   wire        is_cmp;
   wire        is_pwm;
   wire        is_dual;
   wire        hit_reload;

   // Selects prescale divide limit 2^n - 1 from the three-bit code
   function [6:0] pres_limit;
      input [2:0] code;
      begin
         pres_limit = 7'h7f >> (3'h7 - code);
      end
   endfunction

   // Register offset match
   function is_off;
      input [11:0] a;
      input [11:0] off;
      begin
         is_off = (a == off);
      end
   endfunction

   assign acc = psel & penable;
   assign wr  = acc & pwrite;
   assign en  = ctl1_reg[`TPC_C1_EN];
   assign pol = ctl1_reg[`TPC_C1_POL];

   // Mode decode across both control registers
   always @* begin
      mode_next = {ctl0_reg[`TPC_C0_MODEHI],
                   ctl1_reg[`TPC_C1_MODE_MSB:`TPC_C1_MODE_LSB]};
   end
   assign is_cmp  = (mode_next == `TPC_MODE_CMPCNT);
   assign is_dual = (mode_next == `TPC_MODE_PWM2);
   assign is_pwm  = (mode_next == `TPC_MODE_PWM1) | is_dual;
   assign hit_reload = (count_reg == reload_reg);

   // Comparator edge detection; sampling adjacent flops one apart limits
   // useful rate to half of clk with one-cycle phases
   always @(posedge clk) begin
      if (reset) begin
         cmp_q1_reg <= 1'b0;
         cmp_q2_reg <= 1'b0;
         cmp_q3_reg <= 1'b0;
      end else begin
         cmp_q1_reg <= cmp_out;
         cmp_q2_reg <= cmp_q1_reg;
         cmp_q3_reg <= cmp_q2_reg;
      end
   end

   always @* begin
      cmp_edge = pol ? (!cmp_q2_reg & cmp_q3_reg)
                     : (cmp_q2_reg & !cmp_q3_reg);
   end

   // Count advance qualifier
   always @* begin
      if (is_cmp)
         tick = cmp_edge;
      else
         tick = (pres_reg == pres_limit(
                 ctl1_reg[`TPC_C1_PRES_MSB:`TPC_C1_PRES_LSB]));
   end

   // Next count and output level
   always @* begin
      count_next = count_reg;
      out_next   = out_reg;
      if (state_reg == ST_RUN && tick) begin
         if (hit_reload) begin
            count_next = `TPC_COUNT_RST;
            if (is_cmp)
               out_next = ~out_reg;
            else
               out_next = pol;
         end else begin
            count_next = count_reg + 16'h0001;
            if (is_pwm && count_reg == pwm_reg)
               out_next = ~pol;
         end
      end
   end

   // Timer state, count, prescaler and output
   always @(posedge clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         pres_reg  <= 7'h00;
         count_reg <= `TPC_COUNT_RST;
         out_reg   <= 1'b0;
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               pres_reg <= 7'h00;
               out_reg  <= pol;
               if (wr && is_off(paddr, `TPC_OFF_COUNT))
                  count_reg <= pwdata[15:0];
               if (en)
                  state_reg <= ST_RUN;
            end
            ST_RUN: begin
               if (!en) begin
                  state_reg <= ST_IDLE;
               end else begin
                  if (tick || is_cmp)
                     pres_reg <= 7'h00;
                  else
                     pres_reg <= pres_reg + 7'h01;
                  if (wr && is_off(paddr, `TPC_OFF_COUNT))
                     count_reg <= pwdata[15:0];
                  else
                     count_reg <= count_next;
                  out_reg <= out_next;
                  if (tick && hit_reload)
                     timer_irq <= 1'b1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Deadband stages for true and complement outputs
   tpc_deadband u_db_p (
      .clk       (clk),
      .reset     (reset),
      .delay     (db_reg),
      .level_in  (out_reg),
      .level_out (db_p)
   );

   tpc_deadband u_db_n (
      .clk       (clk),
      .reset     (reset),
      .delay     (db_reg),
      .level_in  (~out_reg),
      .level_out (db_n)
   );

   // Pin drivers, registered
   always @(posedge clk) begin
      if (reset) begin
         timer_out          <= 1'b0;
         timer_out_n        <= 1'b0;
         timer_out_en       <= 1'b0;
         shared_pin_is_comp <= 1'b0;
      end else begin
         timer_out    <= is_dual ? db_p : out_reg;
         timer_out_n  <= is_dual ? db_n : 1'b0;
         timer_out_en <= ctl0_reg[`TPC_C0_OUTEN] | is_pwm;
         shared_pin_is_comp <= is_dual;
      end
   end

   // APB register writes; count writes are handled with the timer state
   always @(posedge clk) begin
      if (reset) begin
         ctl0_reg   <= 8'h00;
         ctl1_reg   <= 8'h00;
         reload_reg <= `TPC_RELOAD_RST;
         pwm_reg    <= 16'h0000;
         db_reg     <= 8'h00;
      end else if (wr) begin
         if (is_off(paddr, `TPC_OFF_CTL0))
            ctl0_reg <= pwdata[7:0];
         if (is_off(paddr, `TPC_OFF_CTL1))
            ctl1_reg <= pwdata[7:0];
         if (is_off(paddr, `TPC_OFF_RELOAD))
            reload_reg <= pwdata[15:0];
         if (is_off(paddr, `TPC_OFF_PWM))
            pwm_reg <= pwdata[15:0];
         // Clamp keeps deadband within its documented range
         if (is_off(paddr, `TPC_OFF_DEADBAND))
            db_reg <= (pwdata[7:0] > `TPC_DB_MAX) ? `TPC_DB_MAX
                                                   : pwdata[7:0];
      end
   end

   // APB read and response; zero wait states
   always @(posedge clk) begin
      if (reset) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable) begin
            case (paddr)
               `TPC_OFF_CTL0:     prdata <= {24'h000000, ctl0_reg};
               `TPC_OFF_CTL1:     prdata <= {24'h000000, ctl1_reg};
               `TPC_OFF_COUNT:    prdata <= {16'h0000, count_reg};
               `TPC_OFF_RELOAD:   prdata <= {16'h0000, reload_reg};
               `TPC_OFF_PWM:      prdata <= {16'h0000, pwm_reg};
               `TPC_OFF_DEADBAND: prdata <= {24'h000000, db_reg};
               `TPC_OFF_STATUS:   prdata <= {29'h00000000, timer_out_n,
                                             timer_out, state_reg};
               default:           pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule // tpc_timer
`default_nettype wire

// [testbench/tpc_timer_props.sv]
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins
   input wire logic        timer_out,
   input wire logic        timer_out_en,
   input wire logic        timer_out_n,
   input wire logic        shared_pin_is_comp,
   input wire logic        timer_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   a_ready_next: assert property (s_setup |=> s_access)
      else $error("no answer after setup");
   a_ready_only: assert property (pready |-> psel && penable
      && $past(psel && !penable)) else $error("stray ready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_err_ready: assert property (pslverr |-> pready && paddr > 12'h018)
      else $error("error on mapped address");
   a_err_mapped: assert property (pready && paddr <= 12'h018 |-> !pslverr)
      else $error("mapped access refused");
   a_irq_pulse: assert property (timer_irq |=> !timer_irq)
      else $error("interrupt longer than one cycle");
   a_no_overlap: assert property (!(timer_out && timer_out_n))
      else $error("both outputs active");
   a_comp_only: assert property (!shared_pin_is_comp
      && !$past(shared_pin_is_comp, 3) |-> !timer_out_n)
      else $error("complement outside dual mode");
   a_en_dual: assert property (shared_pin_is_comp |-> timer_out_en)
      else $error("dual mode pin not driven");
endmodule // tpc_timer_props
bind tpc_timer tpc_timer_props tpc_timer_props_i (.clk(clk),
   .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_out(timer_out), .timer_out_en(timer_out_en),
   .timer_out_n(timer_out_n), .shared_pin_is_comp(shared_pin_is_comp),
   .timer_irq(timer_irq));
`default_nettype wire

// [testbench/tpc_cmp_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tpc_cmp_model (
   // Clock
   input  wire logic       clk,
   // Pacing, half period in clocks
   input  wire logic       run,
   input  wire logic [2:0] half,
   // Comparator level
   output var  logic       cmp_out
);
   logic [2:0] cnt_reg;
   initial begin
      cmp_out = 1'b0;
      cnt_reg = 3'h0;
   end
   // Half period of one or more clocks; one-clock phases lose no edges
   always @(posedge clk) begin
      if (!run) begin
         cnt_reg <= 3'h0;
      end else if (cnt_reg == half - 3'h1) begin
         cnt_reg <= 3'h0;
         cmp_out <= ~cmp_out;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end
endmodule // tpc_cmp_model
`default_nettype wire

// [testbench/timer_pwm_comparator_count_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "tpc_map.vh"
module timer_pwm_comparator_count_tb;
   logic        clk, reset, psel, penable, pwrite, run, cq, pol, ev;
   logic        pready, pslverr, cmp, t_out, t_en, t_n, comp, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv, seed, ctl;
   logic [2:0]  half;
   int          n_fail, cmp_count, n_edge, n_irq, n_hi, n_lo;
   int          r, e, s, w, p, d, hi, dv;
   tpc_timer tpc_timer_i (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_out(cmp), .timer_out(t_out),
      .timer_out_en(t_en), .timer_out_n(t_n),
      .shared_pin_is_comp(comp), .timer_irq(irq));
   tpc_cmp_model tpc_cmp_model_i (.clk(clk), .run(run), .half(half),
      .cmp_out(cmp));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Count after e edges from start s with reload r; wraps in w
   function automatic int cnt_exp(input int e, s, r, output int w);
      int c;
      c = s;
      w = 0;
      repeat (e) begin
         w += (c == r);
         c = (c == r) ? 1 : c + 1;
      end
      return c;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do @(posedge clk); while (pready !== 1'b1 && ++k < 20);
      if (k >= 20) n_fail++;
      rv = prdata;
      ev = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic summarize();
      if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cq <= cmp;
      if (cmp !== cq && cmp === !pol) n_edge++;
      if (irq === 1'b1) n_irq++;
      if (t_out === 1'b1) n_hi++;
      if (t_n === 1'b1) n_lo++;
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      summarize();
   end
   initial begin
      {reset, seed} = {1'b1, 32'd12860};
      {psel, penable, pwrite, run, cq, pol} = 6'h0;
      {paddr, pwdata, half} = 47'h2;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      apb(0, `TPC_OFF_RELOAD, 0);
      chk(rv, 32'h0000ffff);
      apb(0, 12'h01c, 0);
      chk(32'(ev), 1);
      // Oversized deadband clamps to the top of its range
      apb(1, `TPC_OFF_DEADBAND, 32'hff);
      apb(0, `TPC_OFF_DEADBAND, 0);
      chk(rv, 32'h00000080);
      for (p = 0; p < 2; p++) begin
         r = 3 + rnd() % 4;
         e = 5 + rnd() % 12;
         s = 1 + p;
         pol = p[0];
         apb(1, `TPC_OFF_CTL1, p << 6);
         apb(1, `TPC_OFF_CTL0, 3);
         apb(1, `TPC_OFF_COUNT, s);
         apb(1, `TPC_OFF_RELOAD, r);
         apb(1, `TPC_OFF_CTL1, (p << 6) | 32'h80);
         repeat (4) @(posedge clk);
         chk(32'(t_out), p);
         @(negedge clk);
         {n_edge, n_irq} = 0;
         @(posedge clk);
         half <= 3'(2 + rnd() % 4);
         run  <= 1'b1;
         while (n_edge < e) @(negedge clk);
         @(posedge clk);
         run <= 1'b0;
         repeat (10) @(posedge clk);
         apb(0, `TPC_OFF_COUNT, 0);
         chk(rv, cnt_exp(e, s, r, w));
         chk(n_irq, w);
         chk(32'(t_out), p ^ (w & 1));
         apb(1, `TPC_OFF_CTL1, p << 6);
      end
      for (int k = 0; k < 4; k++) begin
         p  = 4 + rnd() % 4;
         r  = p + 6 + rnd() % 6;
         d  = k[1] ? 1 + rnd() % 3 : 0;
         dv = 1 << k[0];
         hi = (k[0] ? p : r - p) * dv;
         ctl = (k[0] << 6) | (k[0] << 3) | (k[1] ? 1 : 3);
         apb(1, `TPC_OFF_CTL1, ctl);
         apb(1, `TPC_OFF_CTL0, k[1]);
         apb(1, `TPC_OFF_COUNT, 1);
         apb(1, `TPC_OFF_PWM, p);
         apb(1, `TPC_OFF_DEADBAND, d);
         apb(1, `TPC_OFF_RELOAD, r);
         apb(1, `TPC_OFF_CTL1, ctl | 32'h80);
         repeat (3 * r * dv) @(posedge clk);
         @(negedge clk);
         {n_irq, n_hi, n_lo} = 0;
         repeat (4 * r * dv) @(posedge clk);
         @(negedge clk);
         chk(n_irq, 4);
         chk(n_hi, 4 * (hi - d));
         chk(n_lo, k[1] ? 4 * (r * dv - hi - d) : 0);
         chk(32'(comp), k[1]);
         chk(32'(t_en), 1);
         apb(1, `TPC_OFF_CTL1, ctl);
      end
      summarize();
   end
endmodule // timer_pwm_comparator_count_tb
`default_nettype wire
